// ==== dv/rtk_core_bench.sv ====
`timescale 1ns/10ps
module rtk_core_bench;
   // Short divider keeps a simulated second near 4096 clocks
   localparam int DIV_W = 10;
   localparam int TICK = 2 ** DIV_W;
   localparam logic [7:0] SET_V [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic osc_32k_in = 1'b0;
   logic pf_comp_in = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd, calib_or_powerfail_out, trickle_charge_enable;
   logic [1:0] seen;
   int fail_count = 0;
   int cmp_count = 0;
   always #20 clk_sys = ~clk_sys;
   rtk_core #(.DIV_W(DIV_W)) i_rtk_core (.clk_sys(clk_sys), .rst(rst), .osc_32k_in(osc_32k_in),
      .pf_comp_in(pf_comp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .calib_or_powerfail_out(calib_or_powerfail_out),
      .trickle_charge_enable(trickle_charge_enable));
   rtk_host i_rtk_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check8
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_rtk_host.rd(a, rv);
      check8($sformatf("register %h", a), exp, rv);
   endtask : rd_chk
   // Sync needs two clocks high and two low per time-base edge
   task automatic osc(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         osc_32k_in = 1'b1;
         repeat (2) @(negedge clk_sys);
         osc_32k_in = 1'b0;
         @(negedge clk_sys);
      end
   endtask : osc
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (50000) @(posedge clk_sys);
      fail_count++;
      $display("Error watchdog expected completion seen hang");
      tally_and_finish();
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      rd_chk(rtk_pkg::ADDR_CTL, rtk_pkg::CTL_RST);
      rd_chk(rtk_pkg::ADDR_CAL, rtk_pkg::CAL_RST);
      rd_chk(rtk_pkg::ADDR_CFG, rtk_pkg::CFG_RST);
      rd_chk(8'h0C, 8'h00);
      for (int i = 0; i < 7; i++) rd_chk(rtk_pkg::ADDR_TIME0 + 8'(i), rtk_pkg::TIME_LO[i]);
      i_rtk_host.wr(rtk_pkg::ADDR_CFG, 8'h04);
      repeat (3) @(negedge clk_sys);
      check8("charge", 8'h01, {7'h00, trickle_charge_enable});
      i_rtk_host.wr(rtk_pkg::ADDR_CFG, 8'hFB);
      repeat (3) @(negedge clk_sys);
      check8("charge", 8'h00, {7'h00, trickle_charge_enable});
      rd_chk(rtk_pkg::ADDR_CFG, 8'hFB);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h02);
      for (int i = 0; i < 7; i++) i_rtk_host.wr(rtk_pkg::ADDR_TIME0 + 8'(i), SET_V[i]);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h00);
      osc(TICK - 1);
      // Last edge ticks the core at the very edge that takes the snapshot
      osc_32k_in = 1'b1;
      @(negedge clk_sys);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h01);
      osc_32k_in = 1'b0;
      for (int i = 0; i < 7; i++) rd_chk(rtk_pkg::ADDR_TIME0 + 8'(i), rtk_pkg::TIME_LO[i]);
      osc(TICK);
      rd_chk(rtk_pkg::ADDR_TIME0, 8'h00);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h00);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h01);
      rd_chk(rtk_pkg::ADDR_TIME0, 8'h01);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h00);
      i_rtk_host.wr(rtk_pkg::ADDR_CAL, 8'hE5);
      rd_chk(rtk_pkg::ADDR_CAL, rtk_pkg::CAL_RST);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h04);
      i_rtk_host.wr(rtk_pkg::ADDR_CAL, 8'hE5);
      rd_chk(rtk_pkg::ADDR_CAL, 8'h25);
      pf_comp_in = 1'b0;
      seen = 2'b00;
      for (int i = 0; i < 96; i++) begin
         osc(1);
         seen = seen | (calib_or_powerfail_out === 1'b1 ? 2'b10 : 2'b01);
      end
      check8("square", 8'h03, {6'h00, seen});
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h00);
      repeat (4) @(negedge clk_sys);
      check8("powerfail", 8'h00, {7'h00, calib_or_powerfail_out});
      pf_comp_in = 1'b1;
      repeat (4) @(negedge clk_sys);
      check8("powerfail", 8'h01, {7'h00, calib_or_powerfail_out});
      // Window end loads magnitude 5; doubled edges end the following second 5 edges early
      osc((rtk_pkg::CAL_WIN_S - 2) * TICK - 96 + TICK - 5);
      i_rtk_host.wr(rtk_pkg::ADDR_CTL, 8'h01);
      rd_chk(rtk_pkg::ADDR_TIME0, 8'h08);
      tally_and_finish();
   end
endmodule : rtk_core_bench

// ==== dv/rtk_host.sv ====
`timescale 1ns/10ps
module rtk_host (
   input wire logic clk_sys,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Released buses show the inverse, so a stale value never passes by luck
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : rtk_host

// ==== hw/rtk_core.sv ====
`timescale 1ns/10ps
// Functional notes
// [RQ1] Divide 32.768 kHz time-base to 1 Hz
// [RQ2] Readable writable seconds through year registers
// [RQ3] Read bit rising copies core to holding
// [RQ4] Pending tick completes before snapshot fill
// [RQ5] Holding frozen until read bit cleared
// [RQ6] Write bit locks user time registers
// [RQ7] Write bit clearing loads user into core
// [RQ8] Core counts always except while locked
// [RQ9] Software must not write invalid values
// [RQ10] Config bit 2 enables backup trickle charge
// [RQ11] Lithium systems keep trickle charge off
// [RQ12] Calibration mode outputs 512 Hz square wave
// [RQ13] Otherwise output follows power-fail comparator
// [RQ14] Correction removes or adds time-base pulses
// [RQ15] Sign one adds, zero removes pulses
// [RQ16] Magnitude at bits 4:0 of 01h
// [RQ17] Calibration setting survives backup loss
// [RQ18] Correction writes accepted only in calibration
// [RQ19] Software clears calibration bit to exit
// [RQ20] Calibration enable is control bit 2
// [RQ21] BCD fields roll over at calendar limits
module rtk_core #(
   parameter int DIV_W = 15,
   parameter logic [7:0] CAL_INIT = rtk_pkg::CAL_RST
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic osc_32k_in,
   input wire logic pf_comp_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic calib_or_powerfail_out,
   output logic trickle_charge_enable
);

   typedef logic [rtk_pkg::N_TIME-1:0][7:0] rtk_time_t;

   typedef struct packed {
      logic osc_s1;
      logic osc_s2;
      logic osc_prev;
      logic pf_s1;
      logic pf_s2;
      logic [DIV_W-1:0] div;
      logic [2:0] win;
      logic [rtk_pkg::CAL_MAG_W-1:0] adj;
      rtk_time_t core;
      rtk_time_t user;
      logic [7:0] ctl;
      logic [7:0] cal;
      logic [7:0] cfg;
      logic [7:0] rdata;
      logic pin_out;
      logic tce;
   } rtk_state_t;

   rtk_state_t s_q;
   rtk_state_t s_d;

   // A narrow divider for quick runs wraps at its own top, so it still ticks
   localparam int DIV_END = ((2 ** DIV_W) - 1 < rtk_pkg::DIV_MAX) ?
      (2 ** DIV_W) - 1 : rtk_pkg::DIV_MAX;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = v + 8'h01;
      end
   endfunction : bcd_inc

   function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
      logic [1:0] ymod;
      // Tens digit times ten is two mod four when odd
      ymod = y[1:0] + {y[4], 1'b0};
      unique case (m)
         8'h02: month_days = (ymod == 2'd0) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default: month_days = 8'h31;
      endcase
   endfunction : month_days

   function automatic logic is_time(input logic [7:0] a);
      is_time = (a >= rtk_pkg::ADDR_TIME0) &&
                (a < rtk_pkg::ADDR_TIME0 + 8'(rtk_pkg::N_TIME));
   endfunction : is_time

   logic osc_edge;
   logic tick;
   logic carry;
   logic hour_carry;
   logic [7:0] lim;
   logic [DIV_W:0] sum;
   logic [1:0] step;
   logic [7:0] ctl_new;
   logic [2:0] tidx;

   always_comb begin
      s_d = s_q;
      tick = 1'b0;
      carry = 1'b0;
      hour_carry = 1'b0;
      lim = 8'h00;
      step = 2'd1;
      sum = '0;
      ctl_new = s_q.ctl;
      tidx = 3'(reg_addr - rtk_pkg::ADDR_TIME0);

      // Pins pass two flops before use
      s_d.osc_s1 = osc_32k_in;
      s_d.osc_s2 = s_q.osc_s1;
      s_d.osc_prev = s_q.osc_s2;
      s_d.pf_s1 = pf_comp_in;
      s_d.pf_s2 = s_q.pf_s1;
      osc_edge = s_q.osc_s2 & ~s_q.osc_prev;

      // Divider halts while locked so a loaded time starts clean
      if (osc_edge && !s_q.ctl[rtk_pkg::CTL_WR_BIT]) begin // [RQ8]
         if (s_q.adj != '0) begin
            step = s_q.cal[rtk_pkg::CAL_SIGN_BIT] ? 2'd2 : 2'd0; // [RQ14] [RQ15]
            s_d.adj = s_q.adj - 1'b1;
         end
         sum = {1'b0, s_q.div} + {{(DIV_W - 1){1'b0}}, step};
         if (sum > (DIV_W + 1)'(DIV_END)) begin // [RQ1]
            tick = 1'b1;
            sum = sum - (DIV_W + 1)'(DIV_END + 1);
         end
         s_d.div = sum[DIV_W-1:0];
      end

      // Correction count loads once per window of seconds, then applies on consecutive time-base edges
      if (tick) begin
         s_d.win = s_q.win + 3'd1;
         if (s_q.win == 3'(rtk_pkg::CAL_WIN_S - 1)) begin
            s_d.adj = s_q.cal[rtk_pkg::CAL_MAG_W-1:0]; // [RQ16]
         end
      end

      // BCD calendar carry chain
      carry = tick;
      for (int i = rtk_pkg::F_SEC; i <= rtk_pkg::F_HOUR; i++) begin
         if (carry) begin
            carry = (s_q.core[i] == rtk_pkg::TIME_HI[i]);
            s_d.core[i] = carry ? rtk_pkg::TIME_LO[i] : bcd_inc(s_q.core[i]); // [RQ21]
         end
      end
      hour_carry = carry;
      if (hour_carry) begin
         s_d.core[rtk_pkg::F_DOW] = (s_q.core[rtk_pkg::F_DOW] == rtk_pkg::TIME_HI[rtk_pkg::F_DOW]) ?
            rtk_pkg::TIME_LO[rtk_pkg::F_DOW] : bcd_inc(s_q.core[rtk_pkg::F_DOW]); // [RQ21]
      end
      for (int i = rtk_pkg::F_DATE; i <= rtk_pkg::F_YEAR; i++) begin
         lim = (i == rtk_pkg::F_DATE) ?
            month_days(s_q.core[rtk_pkg::F_MON], s_q.core[rtk_pkg::F_YEAR]) : rtk_pkg::TIME_HI[i];
         if (carry) begin
            carry = (s_q.core[i] == lim);
            s_d.core[i] = carry ? rtk_pkg::TIME_LO[i] : bcd_inc(s_q.core[i]); // [RQ21]
         end
      end

      // Register writes
      if (reg_wr) begin
         if (reg_addr == rtk_pkg::ADDR_CTL) begin
            ctl_new = reg_wdata;
         end
         if (reg_addr == rtk_pkg::ADDR_CAL && s_q.ctl[rtk_pkg::CTL_CAL_BIT]) begin // [RQ18] [RQ20]
            s_d.cal = {2'b00, reg_wdata[5:0]};
         end
         if (reg_addr == rtk_pkg::ADDR_CFG) begin
            s_d.cfg = reg_wdata;
         end
         // Time bytes are taken only under the lock
         if (is_time(reg_addr) && s_q.ctl[rtk_pkg::CTL_WR_BIT]) begin // [RQ6] [RQ2]
            s_d.user[tidx] = reg_wdata;
         end
      end
      s_d.ctl = ctl_new;

      // Lock release loads the core and restarts the second
      if (s_q.ctl[rtk_pkg::CTL_WR_BIT] && !ctl_new[rtk_pkg::CTL_WR_BIT]) begin // [RQ7]
         s_d.core = s_q.user;
         s_d.div = '0;
      end

      // Snapshot takes the post-tick core, so a pending update lands first
      if (!s_q.ctl[rtk_pkg::CTL_RD_BIT] && ctl_new[rtk_pkg::CTL_RD_BIT]) begin // [RQ3] [RQ4]
         s_d.user = s_d.core;
      end

      // Register reads
      if (reg_rd) begin
         if (reg_addr == rtk_pkg::ADDR_CTL) begin
            s_d.rdata = s_q.ctl;
         end else if (reg_addr == rtk_pkg::ADDR_CAL) begin
            s_d.rdata = s_q.cal;
         end else if (reg_addr == rtk_pkg::ADDR_CFG) begin
            s_d.rdata = s_q.cfg;
         end else if (is_time(reg_addr)) begin
            s_d.rdata = s_q.user[tidx]; // [RQ2] [RQ5]
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // Shared pin: square wave tap or comparator level
      if (s_q.ctl[rtk_pkg::CTL_CAL_BIT]) begin
         s_d.pin_out = s_q.div[rtk_pkg::CAL_TAP]; // [RQ12]
      end else begin
         s_d.pin_out = s_q.pf_s2; // [RQ13]
      end
      s_d.tce = s_q.cfg[rtk_pkg::CFG_TCE_BIT]; // [RQ10]
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctl <= rtk_pkg::CTL_RST;
         s_q.cfg <= rtk_pkg::CFG_RST;
         // Stands in for the nonvolatile copy of the setting
         s_q.cal <= CAL_INIT; // [RQ17]
         for (int i = 0; i < rtk_pkg::N_TIME; i++) begin
            s_q.core[i] <= rtk_pkg::TIME_LO[i];
            s_q.user[i] <= rtk_pkg::TIME_LO[i];
         end
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign calib_or_powerfail_out = s_q.pin_out;
   assign trickle_charge_enable = s_q.tce;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_lock_release;
      s_q.ctl[rtk_pkg::CTL_WR_BIT] ##1 !s_q.ctl[rtk_pkg::CTL_WR_BIT];
   endsequence

   sequence s_read_held;
      s_q.ctl[rtk_pkg::CTL_RD_BIT] && !s_q.ctl[rtk_pkg::CTL_WR_BIT] ##1
      s_q.ctl[rtk_pkg::CTL_RD_BIT] && !s_q.ctl[rtk_pkg::CTL_WR_BIT];
   endsequence

   a_tce_pin_follow: assert property (reg_wr && reg_addr == rtk_pkg::ADDR_CFG |-> // [RQ10]
      ##2 trickle_charge_enable == $past(reg_wdata[rtk_pkg::CFG_TCE_BIT], 2))
      else $error("trickle enable does not follow config bit");

   a_cal_write_drop: assert property (reg_wr && reg_addr == rtk_pkg::ADDR_CAL && // [RQ18]
      !s_q.ctl[rtk_pkg::CTL_CAL_BIT] |=> $stable(s_q.cal))
      else $error("correction written outside calibration mode");

   a_cal_write_take: assert property (reg_wr && reg_addr == rtk_pkg::ADDR_CAL && // [RQ16]
      s_q.ctl[rtk_pkg::CTL_CAL_BIT] |=> s_q.cal[5:0] == $past(reg_wdata[5:0]))
      else $error("correction not stored in calibration mode");

   a_pin_square_wave: assert property (s_q.ctl[rtk_pkg::CTL_CAL_BIT] |=> // [RQ12]
      calib_or_powerfail_out == $past(s_q.div[rtk_pkg::CAL_TAP]))
      else $error("calibration pin is not the divider tap");

   a_pin_power_fail: assert property (!s_q.ctl[rtk_pkg::CTL_CAL_BIT] |=> // [RQ13]
      calib_or_powerfail_out == $past(s_q.pf_s2))
      else $error("pin does not follow comparator");

   a_snap_copy: assert property ($rose(s_q.ctl[rtk_pkg::CTL_RD_BIT]) && // [RQ3]
      !$past(s_q.ctl[rtk_pkg::CTL_WR_BIT]) |-> s_q.user == s_q.core)
      else $error("snapshot does not match core");

   a_snap_frozen: assert property (s_read_held |-> $stable(s_q.user)) // [RQ5]
      else $error("holding registers moved while frozen");

   a_core_locked: assert property (s_q.ctl[rtk_pkg::CTL_WR_BIT] && // [RQ8]
      $past(s_q.ctl[rtk_pkg::CTL_WR_BIT]) |-> $stable(s_q.core) && $stable(s_q.div))
      else $error("core counted while locked");

   a_core_load: assert property (s_lock_release |-> s_q.core == $past(s_q.user)) // [RQ7]
      else $error("core not loaded on lock release");

   a_lock_write: assert property (reg_wr && is_time(reg_addr) && // [RQ6]
      s_q.ctl[rtk_pkg::CTL_WR_BIT] |=> s_q.user[$past(tidx)] == $past(reg_wdata))
      else $error("locked time write not stored");

   a_sec_wrap: assert property (tick && s_q.core[rtk_pkg::F_SEC] == 8'h59 |=> // [RQ21]
      s_q.core[rtk_pkg::F_SEC] == 8'h00)
      else $error("seconds failed to roll over");

   a_tick_restart: assert property (tick |=> s_q.div <= DIV_W'(1)) // [RQ1]
      else $error("divider did not restart after the tick");

   a_adj_load: assert property (tick && s_q.win == 3'(rtk_pkg::CAL_WIN_S - 1) |=> // [RQ14]
      s_q.adj == $past(s_q.cal[rtk_pkg::CAL_MAG_W-1:0]))
      else $error("correction count not loaded at window end");

   a_pulse_add: assert property (osc_edge && !s_q.ctl[rtk_pkg::CTL_WR_BIT] && s_q.adj != '0 && // [RQ15]
      s_q.cal[rtk_pkg::CAL_SIGN_BIT] && s_q.div < DIV_W'(DIV_END - 1) |=>
      s_q.div == $past(s_q.div) + DIV_W'(2))
      else $error("positive correction did not add a pulse");

endmodule : rtk_core

// ==== inc/rtk_pkg.sv ====
package rtk_pkg;
   // Register map
   localparam logic [7:0] ADDR_CTL = 8'h00;
   localparam logic [7:0] ADDR_CAL = 8'h01;
   localparam logic [7:0] ADDR_TIME0 = 8'h02;
   localparam logic [7:0] ADDR_CFG = 8'h0B;
   localparam int N_TIME = 7;
   // Field positions
   localparam int CTL_RD_BIT = 0;
   localparam int CTL_WR_BIT = 1;
   localparam int CTL_CAL_BIT = 2;
   localparam int CAL_SIGN_BIT = 5;
   localparam int CAL_MAG_W = 5;
   localparam int CFG_TCE_BIT = 2;
   // Time field indices
   localparam int F_SEC = 0;
   localparam int F_MIN = 1;
   localparam int F_HOUR = 2;
   localparam int F_DOW = 3;
   localparam int F_DATE = 4;
   localparam int F_MON = 5;
   localparam int F_YEAR = 6;
   // Reset values and rollover limits
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] CAL_RST = 8'h00;
   localparam logic [7:0] TIME_LO [N_TIME] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   localparam logic [7:0] TIME_HI [N_TIME] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
   // Timing
   localparam int OSC_HZ = 32768;
   localparam int TICK_HZ = 1;
   localparam int CAL_HZ = 512;
   localparam int DIV_MAX = OSC_HZ / TICK_HZ - 1;
   localparam int CAL_TAP = $clog2(OSC_HZ / CAL_HZ) - 1;
   localparam int CAL_WIN_S = 8;
endpackage : rtk_pkg
